// ==== logic/phymc_pkg.sv ====
// constants for the phy misc control and interrupt register block
package phymc_pkg;
  // register indices and their byte addresses on the bus
  localparam logic [7:0] PHYMC_IDX_FEAT = 8'h10;
  localparam logic [7:0] PHYMC_IDX_IRQ = 8'h11;
  localparam logic [7:0] PHYMC_ADDR_FEAT = 8'(PHYMC_IDX_FEAT * 4);
  localparam logic [7:0] PHYMC_ADDR_IRQ = 8'(PHYMC_IDX_IRQ * 4);
  // features register bit positions
  localparam int PHYMC_B_REPEATER = 15;
  localparam int PHYMC_B_IRQ_POL = 14;
  localparam int PHYMC_B_SQE_INH = 11;
  localparam int PHYMC_B_LOOP10 = 10;
  localparam int PHYMC_B_GP1_DATA = 9;
  localparam int PHYMC_B_GP1_DIR = 8;
  localparam int PHYMC_B_GP0_DATA = 7;
  localparam int PHYMC_B_GP0_DIR = 6;
  localparam int PHYMC_B_APOL_DIS = 5;
  localparam int PHYMC_B_REV_POL = 4;
  localparam int PHYMC_B_RXCLK_CTL = 0;
  // interrupt register layout: enables in the high byte, flags in the low byte
  localparam int PHYMC_IRQ_EN_LSB = 8;
  localparam int PHYMC_NUM_EVT = 8;
  localparam int PHYMC_E_JABBER = 7;
  localparam int PHYMC_E_RXERR = 6;
  localparam int PHYMC_E_PAGE = 5;
  localparam int PHYMC_E_PDFAULT = 4;
  localparam int PHYMC_E_LPACK = 3;
  localparam int PHYMC_E_LINKDN = 2;
  localparam int PHYMC_E_RFAULT = 1;
  localparam int PHYMC_E_ANDONE = 0;
  // values after reset
  localparam logic PHYMC_RST_IRQ_POL = 1'b0;
  localparam logic PHYMC_RST_SQE_INH = 1'b0;
  localparam logic PHYMC_RST_LOOP10 = 1'b0;
  localparam logic PHYMC_RST_GP_DATA = 1'b0;
  localparam logic PHYMC_RST_GP_DIR = 1'b1;
  localparam logic PHYMC_RST_APOL_DIS = 1'b0;
  localparam logic PHYMC_RST_RXCLK_CTL = 1'b0;
  localparam logic [15:0] PHYMC_RST_IRQ_REG = 16'h0000;
  // counts
  localparam int PHYMC_NLP_REV_CNT = 8;
  localparam int PHYMC_RXCLK_HOLD_CYC = 64;
  localparam logic [1:0] PHYMC_STRAP_SETTLE = 2'h2;
endpackage

// ==== logic/phymc_regs.sv ====
// misc features control and interrupt control/status registers behind apb
//
// What this block does
// - repeater bit kills duplex, rx-only crs, sqe; strap reset
// - irq pin polarity follows bit 14, reset low
// - sqe inhibit clear gives col pulse after 10m transmit
// - bit 10 enables 10base-t loopback, resets zero
// - bit 8 sets gpio1 direction, input after reset
// - gpio1 data reads pin as input, drives as output
// - gpio0 same as gpio1 using bits 7 and 6
// - bit 5 disables automatic polarity detection and correction
// - bit 4 reads detected reverse polarity when auto enabled
// - bit 4 write inverts transmitter when auto disabled
// - reverse polarity after eight inverted nlps or flp
// - bit 0 stops rx clock when idle with link
// - loopback or pcs bypass keeps rx clock running
// - interrupt enables in bits 15 to 8, reset zero
// - jabber sets bit 7; flags sticky, clear on read
// - rx error rising edge sets bit 6
// - new page sets bit 5, parallel fault bit 4
// - flp with acknowledge sets bit 3
// - link ok to not-ok sets bit 2
// - remote fault sets bit 1, negotiation done bit 0
`timescale 1ns/1ps
module phymc_regs
  import phymc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins from outside the clock domain
  input wire logic repeater_strap_input,
  input wire logic [1:0] gpio_i,
  output logic [1:0] gpio_o,
  output logic [1:0] gpio_oe,
  output logic irq_output_pin,
  // event inputs from the phy core, same clock
  input wire logic jabber_evt,
  input wire logic rx_er,
  input wire logic page_rx_evt,
  input wire logic pd_fault_evt,
  input wire logic lp_ack_evt,
  input wire logic link_ok,
  input wire logic remote_fault_evt,
  input wire logic aneg_done_evt,
  // polarity detection inputs
  input wire logic nlp_rx,
  input wire logic flp_burst_rx,
  input wire logic rx_pulse_inverted,
  // transmit and receive path controls
  input wire logic tx_done_10m,
  input wire logic pcs_bypass,
  input wire logic ext_loopback,
  input wire logic rx_dv_raw,
  output logic rx_dv,
  output logic rx_clk_en,
  output logic sqe_col_pulse,
  output logic full_duplex_disable,
  output logic crs_rx_only,
  output logic loopback_10m_en,
  output logic rx_polarity_correct,
  output logic tx_polarity_invert
);

  localparam int HOLD_W = $clog2(PHYMC_RXCLK_HOLD_CYC + 1);
  localparam int NLP_W = $clog2(PHYMC_NLP_REV_CNT + 1);

  // control bits
  logic repeater_q;
  logic irq_polarity_select_q;
  logic sqe_inh_q;
  logic loop10_q;
  logic [1:0] gp_data_q;
  logic [1:0] gp_dir_q;
  logic apol_dis_q;
  logic tx_inv_q;
  logic rxclk_ctl_q;
  logic [7:0] irq_en_q;
  logic [7:0] irq_flag_q;
  // synchronisers
  logic strap_s1_q;
  logic strap_s2_q;
  logic [1:0] strap_cnt_q;
  logic [1:0] gp_s1_q;
  logic [1:0] gp_s2_q;
  // event history and polarity state
  logic rx_er_prev_q;
  logic link_ok_prev_q;
  logic [NLP_W-1:0] nlp_cnt_q;
  logic rev_det_q;
  // receive clock gating
  logic rx_dv_d1_q;
  logic [HOLD_W-1:0] hold_q;
  // outputs
  logic [31:0] prdata_q;
  logic [1:0] gp_oe_q;
  logic tx_inv_pin_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic sqe_q;
  logic rx_clk_en_q;
  logic rx_dv_q;

  // bus decode
  logic access;
  logic wr_done;
  logic rd_start;
  logic hit_feat;
  logic hit_irq;
  logic [15:0] feat_rd;
  logic [7:0] evt_set;
  logic gate_on;

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] b);
    return a == ADDR_W'(b);
  endfunction

  assign access = psel & penable;
  assign hit_feat = addr_is(paddr, PHYMC_ADDR_FEAT);
  assign hit_irq = addr_is(paddr, PHYMC_ADDR_IRQ);
  // writes land on the completion edge, reads sample one edge earlier
  assign wr_done = access & pready_q & pwrite;
  assign rd_start = access & ~pready_q & ~pwrite;

  // one wait state on every transfer so the read data can come from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & ~(hit_feat | hit_irq);
    end
  end

  // data bit reads the pin when input, the stored value when output
  always_comb begin
    feat_rd = 16'h0000;
    feat_rd[PHYMC_B_REPEATER] = repeater_q;
    feat_rd[PHYMC_B_IRQ_POL] = irq_polarity_select_q;
    feat_rd[PHYMC_B_SQE_INH] = sqe_inh_q;
    feat_rd[PHYMC_B_LOOP10] = loop10_q;
    feat_rd[PHYMC_B_GP1_DATA] = gp_dir_q[1] ? gp_s2_q[1] : gp_data_q[1];
    feat_rd[PHYMC_B_GP1_DIR] = gp_dir_q[1];
    feat_rd[PHYMC_B_GP0_DATA] = gp_dir_q[0] ? gp_s2_q[0] : gp_data_q[0];
    feat_rd[PHYMC_B_GP0_DIR] = gp_dir_q[0];
    feat_rd[PHYMC_B_APOL_DIS] = apol_dis_q;
    feat_rd[PHYMC_B_REV_POL] = apol_dis_q ? tx_inv_q : rev_det_q;
    feat_rd[PHYMC_B_RXCLK_CTL] = rxclk_ctl_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_start) begin
      if (hit_feat) begin
        prdata_q <= {16'h0000, feat_rd};
      end else if (hit_irq) begin
        prdata_q <= {16'h0000, irq_en_q, irq_flag_q};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // strap passes two flops, then loads the repeater bit once after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
      strap_cnt_q <= 2'h0;
    end else begin
      strap_s1_q <= repeater_strap_input;
      strap_s2_q <= strap_s1_q;
      if (strap_cnt_q != 2'h3) begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp_s1_q <= 2'h0;
      gp_s2_q <= 2'h0;
    end else begin
      gp_s1_q <= gpio_i;
      gp_s2_q <= gp_s1_q;
    end
  end

  // features register; reserved bits are not stored and read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      repeater_q <= 1'b0;
      irq_polarity_select_q <= PHYMC_RST_IRQ_POL;
      sqe_inh_q <= PHYMC_RST_SQE_INH;
      loop10_q <= PHYMC_RST_LOOP10;
      gp_data_q <= {2{PHYMC_RST_GP_DATA}};
      gp_dir_q <= {2{PHYMC_RST_GP_DIR}};
      gp_oe_q <= ~{2{PHYMC_RST_GP_DIR}};
      apol_dis_q <= PHYMC_RST_APOL_DIS;
      tx_inv_q <= 1'b0;
      tx_inv_pin_q <= 1'b0;
      rxclk_ctl_q <= PHYMC_RST_RXCLK_CTL;
    end else begin
      if (strap_cnt_q == PHYMC_STRAP_SETTLE) begin
        repeater_q <= strap_s2_q;
      end else if (wr_done && hit_feat) begin
        repeater_q <= pwdata[PHYMC_B_REPEATER];
      end
      if (wr_done && hit_feat) begin
        irq_polarity_select_q <= pwdata[PHYMC_B_IRQ_POL];
        sqe_inh_q <= pwdata[PHYMC_B_SQE_INH];
        loop10_q <= pwdata[PHYMC_B_LOOP10];
        gp_data_q <= {pwdata[PHYMC_B_GP1_DATA], pwdata[PHYMC_B_GP0_DATA]};
        gp_dir_q <= {pwdata[PHYMC_B_GP1_DIR], pwdata[PHYMC_B_GP0_DIR]};
        // pin enables keep their own flops so the outputs leave straight from a register
        gp_oe_q <= ~{pwdata[PHYMC_B_GP1_DIR], pwdata[PHYMC_B_GP0_DIR]};
        apol_dis_q <= pwdata[PHYMC_B_APOL_DIS];
        rxclk_ctl_q <= pwdata[PHYMC_B_RXCLK_CTL];
        // with auto polarity on, a write to bit 4 is ignored
        if (pwdata[PHYMC_B_APOL_DIS]) begin
          tx_inv_q <= pwdata[PHYMC_B_REV_POL];
        end
        // the pin copy is the stored bit gated by the disable written with it
        tx_inv_pin_q <= pwdata[PHYMC_B_APOL_DIS] & pwdata[PHYMC_B_REV_POL];
      end
    end
  end

  // eight inverted nlps in a row or one inverted flp burst; a normal one clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nlp_cnt_q <= '0;
      rev_det_q <= 1'b0;
    end else if (apol_dis_q) begin
      nlp_cnt_q <= '0;
      rev_det_q <= 1'b0;
    end else if (flp_burst_rx) begin
      nlp_cnt_q <= '0;
      rev_det_q <= rx_pulse_inverted;
    end else if (nlp_rx) begin
      if (!rx_pulse_inverted) begin
        nlp_cnt_q <= '0;
        rev_det_q <= 1'b0;
      end else if (nlp_cnt_q == NLP_W'(PHYMC_NLP_REV_CNT - 1)) begin
        nlp_cnt_q <= '0;
        rev_det_q <= 1'b1;
      end else begin
        nlp_cnt_q <= nlp_cnt_q + NLP_W'(1);
      end
    end
  end

  // interrupt enables and sticky flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_er_prev_q <= 1'b0;
      link_ok_prev_q <= 1'b0;
    end else begin
      rx_er_prev_q <= rx_er;
      link_ok_prev_q <= link_ok;
    end
  end

  always_comb begin
    evt_set = 8'h00;
    evt_set[PHYMC_E_JABBER] = jabber_evt;
    evt_set[PHYMC_E_RXERR] = rx_er & ~rx_er_prev_q;
    evt_set[PHYMC_E_PAGE] = page_rx_evt;
    evt_set[PHYMC_E_PDFAULT] = pd_fault_evt;
    evt_set[PHYMC_E_LPACK] = lp_ack_evt;
    evt_set[PHYMC_E_LINKDN] = link_ok_prev_q & ~link_ok;
    evt_set[PHYMC_E_RFAULT] = remote_fault_evt;
    evt_set[PHYMC_E_ANDONE] = aneg_done_evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q <= PHYMC_RST_IRQ_REG[15:PHYMC_IRQ_EN_LSB];
    end else if (wr_done && hit_irq) begin
      irq_en_q <= pwdata[15:PHYMC_IRQ_EN_LSB];
    end
  end

  // cleared on the edge that samples them into prdata, so nothing is lost;
  // an event on that same edge survives the clear
  genvar gi;
  generate
    for (gi = 0; gi < PHYMC_NUM_EVT; gi++) begin : g_flag
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          irq_flag_q[gi] <= PHYMC_RST_IRQ_REG[gi];
        end else if (evt_set[gi]) begin
          irq_flag_q[gi] <= 1'b1;
        end else if (rd_start && hit_irq) begin
          irq_flag_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // idle level of the pin is the inactive level for the chosen polarity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= ~PHYMC_RST_IRQ_POL;
    end else begin
      irq_q <= (|(irq_flag_q & irq_en_q)) ~^ irq_polarity_select_q;
    end
  end

  // sqe test pulse, also muted in repeater mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sqe_q <= 1'b0;
    end else begin
      sqe_q <= tx_done_10m & ~sqe_inh_q & ~repeater_q;
    end
  end

  // rx_dv is delayed two flops so the clock enable can lead it by one cycle
  assign gate_on = rxclk_ctl_q & link_ok & ~loop10_q & ~ext_loopback & ~pcs_bypass;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_dv_d1_q <= 1'b0;
      rx_dv_q <= 1'b0;
      hold_q <= '0;
      rx_clk_en_q <= 1'b1;
    end else begin
      rx_dv_d1_q <= rx_dv_raw;
      rx_dv_q <= rx_dv_d1_q;
      if (rx_dv_d1_q) begin
        hold_q <= HOLD_W'(PHYMC_RXCLK_HOLD_CYC);
      end else if (hold_q != '0) begin
        hold_q <= hold_q - HOLD_W'(1);
      end
      // last enabled cycle is the 64th after rx_dv falls
      rx_clk_en_q <= ~gate_on | rx_dv_raw | rx_dv_d1_q | (hold_q != '0);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign gpio_o = gp_data_q;
  assign gpio_oe = gp_oe_q;
  assign irq_output_pin = irq_q;
  assign sqe_col_pulse = sqe_q;
  assign rx_dv = rx_dv_q;
  assign rx_clk_en = rx_clk_en_q;
  assign full_duplex_disable = repeater_q;
  assign crs_rx_only = repeater_q;
  assign loopback_10m_en = loop10_q;
  assign rx_polarity_correct = rev_det_q;
  assign tx_polarity_invert = tx_inv_pin_q;

endmodule

// ==== tb/phymc_regs_props.sv ====
// assertions on the sqe, repeater and receive clock pins
`timescale 1ns/1ps
module phymc_regs_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // watched pins
  input wire logic tx_done_10m,
  input wire logic sqe_col_pulse,
  input wire logic full_duplex_disable,
  input wire logic crs_rx_only,
  input wire logic rx_dv_raw,
  input wire logic rx_dv,
  input wire logic rx_clk_en,
  input wire logic link_ok,
  input wire logic ext_loopback,
  input wire logic pcs_bypass,
  input wire logic loopback_10m_en
);
  logic [6:0] idle_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // saturates so a long idle spell never wraps back under the stop delay
  always_ff @(posedge pclk or negedge presetn) begin
    // no receive since reset counts as a long idle spell
    if (!presetn) idle_q <= 7'h7f;
    else if (rx_dv) idle_q <= 7'h00;
    else if (idle_q != 7'h7f) idle_q <= idle_q + 7'h01;
  end
  sequence s_dv_up; !rx_dv ##1 rx_dv; endsequence
  sequence s_keep; (ext_loopback || pcs_bypass || loopback_10m_en) [*2]; endsequence
  property p_rpt_pins; full_duplex_disable == crs_rx_only; endproperty
  a_rpt_pins: assert property (p_rpt_pins) else $error("duplex and crs differ");
  property p_sqe_rpt; full_duplex_disable && tx_done_10m |=> !sqe_col_pulse; endproperty
  a_sqe_rpt: assert property (p_sqe_rpt) else $error("sqe in repeater mode");
  property p_sqe_cause; sqe_col_pulse |-> $past(tx_done_10m); endproperty
  a_sqe_cause: assert property (p_sqe_cause) else $error("sqe without transmit");
  property p_dv_delay; $rose(rx_dv_raw) |-> ##2 rx_dv; endproperty
  a_dv_delay: assert property (p_dv_delay) else $error("rx_dv late");
  property p_clk_lead; s_dv_up |-> $past(rx_clk_en); endproperty
  a_clk_lead: assert property (p_clk_lead) else $error("rx clock not ahead");
  property p_clk_stop; $fell(rx_clk_en) |-> idle_q >= 7'h40; endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("rx clock stopped early");
  property p_clk_keep; s_keep |-> rx_clk_en; endproperty
  a_clk_keep: assert property (p_clk_keep) else $error("rx clock gated in loopback");
  property p_clk_nolink; !link_ok ##1 !link_ok |-> rx_clk_en; endproperty
  a_clk_nolink: assert property (p_clk_nolink) else $error("rx clock gated, no link");
endmodule

bind phymc_regs phymc_regs_props u_phymc_regs_props (
  .pclk(pclk), .presetn(presetn), .tx_done_10m(tx_done_10m),
  .sqe_col_pulse(sqe_col_pulse), .full_duplex_disable(full_duplex_disable),
  .crs_rx_only(crs_rx_only), .rx_dv_raw(rx_dv_raw), .rx_dv(rx_dv), .rx_clk_en(rx_clk_en),
  .link_ok(link_ok), .ext_loopback(ext_loopback), .pcs_bypass(pcs_bypass),
  .loopback_10m_en(loopback_10m_en)
);

// ==== tb/phymc_apb_host.sv ====
// apb requester standing in for the management controller
`timescale 1ns/1ps
module phymc_apb_host
  import phymc_pkg::*;
(
  // clock
  input wire logic pclk,
  // apb requester
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    r = 32'h0;
    e = 1'b0;
    if (w && a != PHYMC_ADDR_FEAT && a != PHYMC_ADDR_IRQ) return;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= (a == PHYMC_ADDR_FEAT) ? (d & 32'h0000cff1) : d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep looking valid
    paddr <= ~a;
    pwdata <= ~pwdata;
  endtask
endmodule

// ==== tb/phymc_regs_tb.sv ====
// self-checking bench for the misc features and interrupt registers
`timescale 1ns/1ps
module phymc_regs_tb;
  import phymc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, repeater_strap_input;
  logic irq_output_pin, lk, err, rx_pulse_inverted, tx_done_10m, pcs_bypass, ext_loopback;
  logic rx_dv_raw, rx_dv, rx_clk_en, sqe_col_pulse, full_duplex_disable, crs_rx_only;
  logic loopback_10m_en, rx_polarity_correct, tx_polarity_invert, jabber_evt, rx_er;
  logic page_rx_evt, pd_fault_evt, lp_ack_evt, link_ok, remote_fault_evt, aneg_done_evt;
  logic nlp_rx, flp_burst_rx;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] s = 32'd70;
  logic [1:0] gpio_i, gpio_o, gpio_oe;
  logic [10:0] ev;
  int n_mismatch, checked, f, ninv;
  int rxt[6] = '{32'h100000, 32'h140001, 32'h120001, 32'h110001, 32'h100401, 32'h000001};
  assign {jabber_evt, rx_er, page_rx_evt, pd_fault_evt, lp_ack_evt} = ev[7:3];
  assign link_ok = lk & !ev[2];
  assign {remote_fault_evt, aneg_done_evt} = ev[1:0];
  assign {flp_burst_rx, nlp_rx, tx_done_10m} = ev[10:8];
  phymc_regs u_phymc_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .repeater_strap_input, .gpio_i, .gpio_o, .gpio_oe,
    .irq_output_pin, .jabber_evt, .rx_er, .page_rx_evt, .pd_fault_evt, .lp_ack_evt, .link_ok,
    .remote_fault_evt, .aneg_done_evt, .nlp_rx, .flp_burst_rx, .rx_pulse_inverted,
    .tx_done_10m, .pcs_bypass, .ext_loopback, .rx_dv_raw, .rx_dv, .rx_clk_en, .sqe_col_pulse,
    .full_duplex_disable, .crs_rx_only, .loopback_10m_en, .rx_polarity_correct,
    .tx_polarity_invert);
  phymc_apb_host u_phymc_apb_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  // expected features read: input pins and the detector show through
  function automatic logic [31:0] fexp();
    logic [31:0] v;
    v = f;
    if (f[8]) v[9] = gpio_i[1];
    if (f[6]) v[7] = gpio_i[0];
    if (!f[5]) v[4] = (ninv >= 8);
    return v;
  endfunction
  task automatic complete_run();
    if (n_mismatch == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
    checked++;
    if (v !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_phymc_apb_host.xfer(1'b1, a, d, rd, err);
    if (a == PHYMC_ADDR_FEAT) f = d & 32'hcff1;
    if (f[5]) ninv = 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    u_phymc_apb_host.xfer(1'b0, a, 32'h0, rd, err);
    chk("prdata", e, rd);
  endtask
  task automatic pins();
    cyc(2);
    chk("pins", {~f[8], ~f[6], f[9], f[7], f[10], f[15], f[15], f[4] & f[5], ~f[14]},
      {gpio_oe, gpio_o, loopback_10m_en, full_duplex_disable, crs_rx_only,
       tx_polarity_invert, irq_output_pin});
  endtask
  task automatic pulse(input int b);
    @(posedge pclk);
    ev[b] <= 1'b1;
    @(posedge pclk);
    ev[b] <= 1'b0;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    presetn = 1'b0;
    repeater_strap_input = 1'b1;
    gpio_i = 2'b10;
    ev = 11'h0;
    lk = 1'b1;
    rx_pulse_inverted = 1'b0;
    pcs_bypass = 1'b0;
    ext_loopback = 1'b0;
    rx_dv_raw = 1'b0;
    ninv = 0;
    f = 32'h8140;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    cyc(5);
    rdc(PHYMC_ADDR_FEAT, fexp());
    rdc(PHYMC_ADDR_IRQ, 32'h0);
    pins();
    rdc(8'h48, 32'h0);
    chk("pslverr", 32'h1, err);
    for (int i = 0; i < 12; i++) begin
      @(posedge pclk);
      gpio_i <= 2'(rnd());
      cyc(3);
      wr(PHYMC_ADDR_FEAT, rnd() & 32'hffff);
      pins();
      rdc(PHYMC_ADDR_FEAT, fexp());
    end
    wr(PHYMC_ADDR_IRQ, 32'hff00);
    for (int i = 0; i < 8; i++) begin
      pulse(i);
      cyc(1);
      chk("irq", f[14], irq_output_pin);
      rdc(PHYMC_ADDR_IRQ, 32'hff00 | (1 << i));
      rdc(PHYMC_ADDR_IRQ, 32'hff00);
      cyc(2);
      chk("irq", !f[14], irq_output_pin);
    end
    wr(PHYMC_ADDR_IRQ, 32'h7f00);
    pulse(7);
    cyc(3);
    chk("irq", !f[14], irq_output_pin);
    rdc(PHYMC_ADDR_IRQ, 32'h7f80);
    wr(PHYMC_ADDR_FEAT, 32'h0140);
    rx_pulse_inverted <= 1'b1;
    for (int k = 1; k < 9; k++) begin
      pulse(9);
      ninv = k;
      rdc(PHYMC_ADDR_FEAT, fexp());
      chk("rx_polarity_correct", ninv >= 8, rx_polarity_correct);
    end
    for (int j = 0; j < 2; j++) begin
      rx_pulse_inverted <= 1'(j);
      pulse(10);
      ninv = 8 * j;
      rdc(PHYMC_ADDR_FEAT, fexp());
      chk("rx_polarity_correct", ninv >= 8, rx_polarity_correct);
    end
    for (int i = 0; i < 3; i++) begin
      wr(PHYMC_ADDR_FEAT, i == 0 ? 32'h0 : (i == 1 ? 32'h800 : 32'h8000));
      pulse(8);
      #1 chk("sqe", i == 0, sqe_col_pulse);
    end
    foreach (rxt[i]) begin
      wr(PHYMC_ADDR_FEAT, rxt[i] & 32'hffff);
      {ext_loopback, pcs_bypass} <= rxt[i][18:17];
      lk <= !rxt[i][16];
      cyc(70);
      chk("rx_clk_en", rxt[i][20], rx_clk_en);
    end
    @(posedge pclk);
    rx_dv_raw <= 1'b1;
    cyc(1);
    chk("rx_clk_en", 32'h1, rx_clk_en);
    chk("rx_dv", 32'h0, rx_dv);
    @(posedge pclk);
    rx_dv_raw <= 1'b0;
    #1 chk("rx_dv", 32'h1, rx_dv);
    cyc(65);
    chk("rx_clk_en", 32'h1, rx_clk_en);
    cyc(1);
    chk("rx_clk_en", 32'h0, rx_clk_en);
    // second reset with the strap low: the repeater bit follows the strap
    wr(PHYMC_ADDR_FEAT, 32'h8000);
    repeater_strap_input <= 1'b0;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    cyc(5);
    f = 32'h0140;
    ninv = 0;
    chk("rx_clk_en", 32'h1, rx_clk_en);
    pins();
    rdc(PHYMC_ADDR_FEAT, fexp());
    complete_run();
  end
endmodule
